// ### core/dcp_channel.sv
/*
  One PWM channel: ten-bit timer, duty latch, dead time and the
  true and inverted output stages with enables and active levels.
  Assumes tick_i and dtick_i are one-cycle enables from prescalers.
*/
module dcp_channel
  import dcp_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic tick_i, // timer increment enable
  input wire logic dtick_i, // dead-time count enable
  input wire logic run_i, // channel timer enable
  input wire logic [dcp_pkg::DCP_TW-1:0] prd_i, // period value
  input wire logic [dcp_pkg::DCP_TW-1:0] dty_i, // duty value
  input wire logic dead_en_i, // dead time on
  input wire logic [7:0] dead_i, // dead interval
  input wire logic ten_i, // true output enable
  input wire logic ien_i, // inverted output enable
  input wire logic tlv_i, // true output active level
  input wire logic ilv_i, // inverted output active level
  output logic [dcp_pkg::DCP_TW-1:0] cnt_o, // timer count
  output logic pev_o, // period match pulse
  output logic dev_o, // duty match pulse
  output logic pwm_o, // true output pin
  output logic pwm_n_o // inverted output pin
);
  typedef struct packed {
    logic [DCP_TW-1:0] cnt;
    logic [DCP_TW-1:0] dl;
    logic raw;
    logic [7:0] dcnt;
    logic pev;
    logic dev;
    logic po;
    logic pno;
  } dcp_chan_t;
  dcp_chan_t s_q, s_d;
  logic dz;
  logic tact;
  logic iact;
  logic wrap;

  // ==========================================================
  // Timer, duty latch and raw waveform
  // ==========================================================
  assign wrap = tick_i && run_i && (s_q.cnt == prd_i);
  assign dz = !dead_en_i || (s_q.dcnt == DCP_RST8);
  assign tact = s_q.raw && dz;
  assign iact = !s_q.raw && dz;

  always_comb begin
    s_d = s_q;
    s_d.pev = 1'b0;
    s_d.dev = 1'b0;
    if (tick_i && run_i) begin
      if (wrap) begin
        s_d.cnt = DCP_RST10;
        s_d.dl = dty_i;
        s_d.raw = (dty_i != DCP_RST10);
        s_d.pev = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_d.cnt == s_q.dl && s_q.raw) begin
          s_d.raw = 1'b0;
          s_d.dev = 1'b1;
        end
      end
    end
    if (s_d.raw != s_q.raw) begin
      s_d.dcnt = dead_i;
    end else if (dtick_i && s_q.dcnt != DCP_RST8) begin
      s_d.dcnt = s_q.dcnt - 1'b1;
    end
    s_d.po = ten_i && (tlv_i ? tact : !tact);
    s_d.pno = ien_i && (ilv_i ? iact : !iact);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cnt_o = s_q.cnt;
  assign pev_o = s_q.pev;
  assign dev_o = s_q.dev;
  assign pwm_o = s_q.po;
  assign pwm_n_o = s_q.pno;

  // ==========================================================
  // Checks
  // ==========================================================
  a_wrap_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wrap |=> (s_q.cnt == DCP_RST10) && s_q.pev)
    else $error("timer did not clear on period match");
  a_duty_latch: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wrap |=> s_q.dl == $past(dty_i))
    else $error("duty not latched at timer clear");
  a_timer_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !run_i |=> s_q.cnt == $past(s_q.cnt))
    else $error("stopped timer moved");
  // With dead time on and a nonzero dead interval, right after a raw edge neither phase may be active yet.
  a_no_overlap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    dead_en_i && $past(dead_i) != DCP_RST8 && $changed(s_q.raw)
    |-> !tact && !iact)
    else $error("complementary phases overlap");
  a_off_low: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ten_i |=> !pwm_o)
    else $error("disabled true output driven");
  a_pol_true: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ten_i && !dead_en_i |=> pwm_o == ($past(s_q.raw) ~^ $past(tlv_i)))
    else $error("true output polarity wrong");
endmodule

// ### core/dcp_pkg.sv
/*
  Constants shared by the two-channel PWM block: register indices,
  field positions, widths and reset values.
  Assumes a Wishbone byte address; a register index is addr / 4.
*/
package dcp_pkg;
  // ==========================================================
  // Widths
  // ==========================================================
  localparam int DCP_TW = 10;
  localparam int DCP_PSW = 3;
  localparam int DCP_DPW = 2;
  localparam int DCP_HIW = 2;
  localparam int DCP_IDX_LO = 2;
  localparam int DCP_IDX_HI = 7;
  localparam logic [7:0] DCP_RST8 = 8'h00;
  localparam logic [9:0] DCP_RST10 = 10'h000;
  localparam logic [3:0] DCP_RST4 = 4'h0;
  // ==========================================================
  // Register indices
  // ==========================================================
  localparam logic [7:0] IX_DTC = 8'h14;
  localparam logic [7:0] IX_DTV = 8'h15;
  localparam logic [7:0] IX_OSEL = 8'h16;
  localparam logic [7:0] IX_ACR = 8'h17;
  localparam logic [7:0] IX_APL = 8'h18;
  localparam logic [7:0] IX_APH = 8'h19;
  localparam logic [7:0] IX_ADL = 8'h1A;
  localparam logic [7:0] IX_ADH = 8'h1B;
  localparam logic [7:0] IX_ACL = 8'h1C;
  localparam logic [7:0] IX_ACH = 8'h1D;
  localparam logic [7:0] IX_BCR = 8'h1E;
  localparam logic [7:0] IX_BPL = 8'h1F;
  localparam logic [7:0] IX_BPH = 8'h20;
  localparam logic [7:0] IX_BDL = 8'h21;
  localparam logic [7:0] IX_BDH = 8'h22;
  localparam logic [7:0] IX_BCL = 8'h23;
  localparam logic [7:0] IX_BCH = 8'h24;
  localparam logic [7:0] IX_FLG = 8'h25;
  localparam logic [7:0] IX_CLR = 8'h26;
  localparam logic [7:0] IX_MSK = 8'h27;
  // ==========================================================
  // Fields
  // ==========================================================
  localparam int CR_TEN = 7;
  localparam int CR_IEN = 6;
  localparam int CR_TLV = 5;
  localparam int CR_ILV = 4;
  localparam int CR_RUN = 3;
  localparam int DT_BE = 3;
  localparam int DT_AE = 2;
  localparam int FL_AD = 0;
  localparam int FL_AP = 1;
  localparam int FL_BD = 2;
  localparam int FL_BP = 3;
  localparam logic [7:0] DCP_DTC_MASK = 8'h0F;
  localparam logic [7:0] DCP_OSEL_MASK = 8'h13;
endpackage

// ### core/dcp_presc.sv
/*
  Clock prescaler: one-cycle tick every 2**sel clocks while enabled.
  Assumes a single clock; the count restarts whenever it is disabled.
*/
module dcp_presc #(
  parameter int W = 3
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic en_i, // run the divider
  input wire logic [W-1:0] sel_i, // divide by 2**sel
  output logic tick_o // one-cycle enable
);
  import dcp_pkg::*;
  localparam int CW = (1 << W) - 1;
  typedef struct packed {
    logic [CW-1:0] cnt;
  } dcp_presc_t;
  dcp_presc_t s_q, s_d;
  logic [CW-1:0] m;

  always_comb begin
    for (int i = 0; i < CW; i++) begin
      m[i] = (i < int'(sel_i));
    end
    s_d = s_q;
    if (!en_i) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  assign tick_o = en_i && ((s_q.cnt & m) == m);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ### core/dcp_top.sv
/*
  Two-channel PWM with complementary outputs behind a classic
  Wishbone slave; registers sit one per word at byte address 4*index.
  Assumes one 25 MHz clock, synchronous reset and a single-cycle
  Wishbone master that holds its request until ack.
*/
// The Wishbone slave port was chosen for this implementation.
// Notes on behaviour
// - Each channel counts, compares and holds period and duty in ten bits split as low byte and two-bit high part.
// - The output is high from the start of each period until the latched duty point.
// - True and inverted outputs each have an enable and share one period and duty.
// - Each output follows its own active-level bit.
// - At period match the next increment clears the timer, sets the output unless duty is zero and raises the period flag.
// - Duty may be written any time and is copied into the latch when the timer clears; a latch match clears the output.
// - A cleared timer enable stops the timer, which software cannot load.
// - With dead time on, the complementary active phases are separated by the dead interval.
module dcp_top
  import dcp_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic irq_o, // level interrupt
  output logic pwm_a_o, // channel A true
  output logic pwm_a_n_o, // channel A inverted
  output logic pwm_b_o, // channel B true
  output logic pwm_b_n_o // channel B inverted
);
  typedef struct packed {
    logic [7:0] dtc;
    logic [7:0] dtv;
    logic [7:0] osel;
    logic [7:0] acr;
    logic [7:0] bcr;
    logic [DCP_TW-1:0] aprd;
    logic [DCP_TW-1:0] adty;
    logic [DCP_TW-1:0] bprd;
    logic [DCP_TW-1:0] bdty;
    logic [3:0] flg;
    logic [3:0] msk;
    logic ack;
    logic [7:0] rdat;
  } dcp_regs_t;
  dcp_regs_t s_q, s_d;

  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wd;
  logic [3:0] clr;
  logic [3:0] ev;
  logic ta_tick;
  logic tb_tick;
  logic d_tick;
  logic [DCP_TW-1:0] a_cnt;
  logic [DCP_TW-1:0] b_cnt;
  logic a_pev;
  logic a_dev;
  logic b_pev;
  logic b_dev;

  // ==========================================================
  // Prescalers
  // ==========================================================
  // timer clock division.
  dcp_presc #(.W(DCP_PSW)) u_pa (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(s_q.acr[CR_RUN]),
    .sel_i(s_q.acr[DCP_PSW-1:0]),
    .tick_o(ta_tick)
  );

  dcp_presc #(.W(DCP_PSW)) u_pb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(s_q.bcr[CR_RUN]),
    .sel_i(s_q.bcr[DCP_PSW-1:0]),
    .tick_o(tb_tick)
  );

  // The dead-time divider runs free so both channels share it.
  dcp_presc #(.W(DCP_DPW)) u_pd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(1'b1),
    .sel_i(s_q.dtc[DCP_DPW-1:0]),
    .tick_o(d_tick)
  );

  // ==========================================================
  // Channels
  // ==========================================================
  dcp_channel u_cha (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(ta_tick),
    .dtick_i(d_tick),
    .run_i(s_q.acr[CR_RUN]),
    .prd_i(s_q.aprd),
    .dty_i(s_q.adty),
    .dead_en_i(s_q.dtc[DT_AE]),
    .dead_i(s_q.dtv),
    .ten_i(s_q.acr[CR_TEN]),
    .ien_i(s_q.acr[CR_IEN]),
    .tlv_i(s_q.acr[CR_TLV]),
    .ilv_i(s_q.acr[CR_ILV]),
    .cnt_o(a_cnt),
    .pev_o(a_pev),
    .dev_o(a_dev),
    .pwm_o(pwm_a_o),
    .pwm_n_o(pwm_a_n_o)
  );

  dcp_channel u_chb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tb_tick),
    .dtick_i(d_tick),
    .run_i(s_q.bcr[CR_RUN]),
    .prd_i(s_q.bprd),
    .dty_i(s_q.bdty),
    .dead_en_i(s_q.dtc[DT_BE]),
    .dead_i(s_q.dtv),
    .ten_i(s_q.bcr[CR_TEN]),
    .ien_i(s_q.bcr[CR_IEN]),
    .tlv_i(s_q.bcr[CR_TLV]),
    .ilv_i(s_q.bcr[CR_ILV]),
    .cnt_o(b_cnt),
    .pev_o(b_pev),
    .dev_o(b_dev),
    .pwm_o(pwm_b_o),
    .pwm_n_o(pwm_b_n_o)
  );

  // ==========================================================
  // Bus decode
  // ==========================================================
  // Only byte lane 0 carries data; a write without it is ignored.
  assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign idx = {2'b00, wb_adr_i[DCP_IDX_HI:DCP_IDX_LO]};
  assign wd = wb_dat_i[7:0];
  assign clr = (wr && idx == IX_CLR) ? wd[3:0] : DCP_RST4;
  assign ev = {b_pev, b_dev, a_pev, a_dev};

  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    // Set wins over a clear in the same cycle.
    s_d.flg = (s_q.flg & ~clr) | ev;
    if (wr) begin
      case (idx)
        IX_DTC: s_d.dtc = wd & DCP_DTC_MASK;
        IX_DTV: s_d.dtv = wd;
        IX_OSEL: s_d.osel = wd & DCP_OSEL_MASK;
        IX_ACR: s_d.acr = wd;
        IX_BCR: s_d.bcr = wd;
        // period and duty split into two bytes.
        IX_APL: s_d.aprd[7:0] = wd;
        IX_APH: s_d.aprd[DCP_TW-1:8] = wd[DCP_HIW-1:0];
        IX_ADL: s_d.adty[7:0] = wd;
        IX_ADH: s_d.adty[DCP_TW-1:8] = wd[DCP_HIW-1:0];
        IX_BPL: s_d.bprd[7:0] = wd;
        IX_BPH: s_d.bprd[DCP_TW-1:8] = wd[DCP_HIW-1:0];
        IX_BDL: s_d.bdty[7:0] = wd;
        IX_BDH: s_d.bdty[DCP_TW-1:8] = wd[DCP_HIW-1:0];
        IX_MSK: s_d.msk = wd[3:0];
        default: s_d.msk = s_q.msk;
      endcase
    end
    s_d.rdat = DCP_RST8;
    if (req && !wb_we_i) begin
      case (idx)
        IX_DTC: s_d.rdat = s_q.dtc;
        IX_DTV: s_d.rdat = s_q.dtv;
        IX_OSEL: s_d.rdat = s_q.osel;
        IX_ACR: s_d.rdat = s_q.acr;
        IX_BCR: s_d.rdat = s_q.bcr;
        IX_APL: s_d.rdat = s_q.aprd[7:0];
        IX_APH: s_d.rdat = {6'h00, s_q.aprd[DCP_TW-1:8]};
        IX_ADL: s_d.rdat = s_q.adty[7:0];
        IX_ADH: s_d.rdat = {6'h00, s_q.adty[DCP_TW-1:8]};
        IX_BPL: s_d.rdat = s_q.bprd[7:0];
        IX_BPH: s_d.rdat = {6'h00, s_q.bprd[DCP_TW-1:8]};
        IX_BDL: s_d.rdat = s_q.bdty[7:0];
        IX_BDH: s_d.rdat = {6'h00, s_q.bdty[DCP_TW-1:8]};
        IX_ACL: s_d.rdat = a_cnt[7:0];
        IX_ACH: s_d.rdat = {6'h00, a_cnt[DCP_TW-1:8]};
        IX_BCL: s_d.rdat = b_cnt[7:0];
        IX_BCH: s_d.rdat = {6'h00, b_cnt[DCP_TW-1:8]};
        IX_FLG: s_d.rdat = {4'h0, s_q.flg};
        IX_MSK: s_d.rdat = {4'h0, s_q.msk};
        default: s_d.rdat = DCP_RST8;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {24'h000000, s_q.rdat};
  assign irq_o = |(s_q.flg & s_q.msk);

  // ==========================================================
  // Checks
  // ==========================================================
  a_ack_answer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  a_ack_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // Read data must be zero whenever no answer stands on the bus.
  a_rdat_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data driven outside an answer");
  a_irq_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    a_pev && s_q.msk[FL_AP] |=> irq_o && s_q.flg[FL_AP])
    else $error("period event did not raise interrupt");
  a_irq_chan_b: assert property (
    @(posedge clk_i) disable iff (rst_i)
    b_pev && s_q.msk[FL_BP] |=> irq_o && s_q.flg[FL_BP])
    else $error("channel B period event did not raise interrupt");
  // A clear in the same cycle as the event must not win.
  a_duty_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    a_dev |=> s_q.flg[FL_AD])
    else $error("duty match not flagged");
  a_flag_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == IX_CLR && wd[FL_AP] && !a_pev |=> !s_q.flg[FL_AP])
    else $error("period flag survived its clear");
  a_prd_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == IX_BPH
    |=> s_q.bprd[DCP_TW-1:8] == $past(wd[DCP_HIW-1:0]))
    else $error("period high part not stored");
  a_count_ro: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && idx == IX_ACL |=> s_q.rdat == $past(a_cnt[7:0]))
    else $error("count readback wrong");
  a_count_nowr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && idx == IX_ACL && !s_q.acr[CR_RUN] |=> a_cnt == $past(a_cnt))
    else $error("count register took a write");
endmodule

// ### test/tb_dcp_top.sv
/*
  Self-checking bench for the two-channel PWM block: Wishbone register
  tasks, waveform duty counts, event flags and the interrupt output.
  Assumes dcp_pkg and dcp_top are compiled first; single 25 MHz clock.
*/
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  err_count++; $display("unexpected at %0t: got %0h expected %0h", \
  $time, got, exp); end end

module tb_dcp_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dcp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, irq, pa, pan, pb, pbn;
  logic [7:0] rv, rv2;
  logic [23:0] hi;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int ha, hn, hb, hbn, ov;
  logic [7:0] acr_tab [4] = '{8'hF8, 8'hC8, 8'hE8, 8'h08};
  int exp_a [4] = '{12, 28, 12, 0};
  int exp_n [4] = '{28, 12, 12, 0};

  dcp_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .pwm_a_o(pa), .pwm_a_n_o(pan), .pwm_b_o(pb), .pwm_b_n_o(pbn));

  always #20 clk_i = ~clk_i;

  // ==========================================================
  // Closing report
  // ==========================================================
  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The ceiling is several times the expected run, so only a hang hits it.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      $display("unexpected at %0t: bench timeout", $time);
      conclude();
    end
  end

  // ==========================================================
  // Bus tasks
  // ==========================================================
  task automatic wb(input logic w, input logic [7:0] ix,
                    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {ix[5:0], 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    hi = rdat[31:8];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, ix, d, q);
  endtask

  task automatic rd(input logic [7:0] ix, input logic [7:0] e);
    wb(1'b0, ix, 8'h00, rv);
    `CHK(rv, e);
    `CHK(hi, 24'h000000);
  endtask

  // Counts over a whole number of periods, so the phase does not matter.
  task automatic meas(input int n);
    ha = 0; hn = 0; hb = 0; hbn = 0; ov = 0;
    repeat (n) begin
      @(posedge clk_i);
      ha += (pa === 1'b1);
      hn += (pan === 1'b1);
      hb += (pb === 1'b1);
      hbn += (pbn === 1'b1);
      ov += (pa === 1'b1 && pan === 1'b1);
    end
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 8'h14; i <= 8'h27; i++) rd(8'(i), 8'h00);
    rd(8'h30, 8'h00);
    wr(IX_BPH, 8'hFF);
    rd(IX_BPH, 8'h03);
    wr(IX_BDH, 8'hFF);
    rd(IX_BDH, 8'h03);
    wr(IX_BPH, 8'h00);
    wr(IX_BDH, 8'h00);
    wr(IX_DTC, 8'hFF);
    rd(IX_DTC, 8'h0F);
    wr(IX_DTC, 8'h00);
    // period 9, duty 3, then levels, timer enable last.
    wr(IX_APL, 8'd9);
    wr(IX_ADL, 8'd3);
    wr(IX_ACR, 8'hF0);
    `CHK(pa, 1'b0);
    wr(IX_ACR, 8'hF8);
    for (int k = 0; k < 4; k++) begin
      wr(IX_ACR, acr_tab[k]);
      repeat (30) @(posedge clk_i);
      meas(40);
      `CHK(ha, exp_a[k]);
      `CHK(hn, exp_n[k]);
    end
    rd(IX_FLG, 8'h03);
    `CHK(irq, 1'b0);
    wr(IX_MSK, 8'h02);
    @(posedge clk_i);
    `CHK(irq, 1'b1);
    // Stop A, then the timer must hold and ignore writes.
    wr(IX_ACR, 8'hF0);
    wb(1'b0, IX_ACL, 8'h00, rv2);
    wr(IX_ACL, 8'hFF);
    repeat (5) @(posedge clk_i);
    rd(IX_ACL, rv2);
    rd(IX_ACH, 8'h00);
    `CHK(rv2 <= 8'd9, 1'b1);
    wr(IX_CLR, 8'h0F);
    rd(IX_FLG, 8'h00);
    @(posedge clk_i);
    `CHK(irq, 1'b0);
    // Dead time on A: the two active phases never overlap.
    wr(IX_DTV, 8'h01);
    wr(IX_DTC, 8'h04);
    wr(IX_ACR, 8'hF8);
    repeat (30) @(posedge clk_i);
    meas(40);
    `CHK(ov, 0);
    `CHK(ha, 8);
    `CHK(hn, 24);
    // Channel B with prescale 1: period 5 ticks of 2 clocks, duty 2.
    wr(IX_BPL, 8'd4);
    wr(IX_BDL, 8'd2);
    wr(IX_BCR, 8'hF9);
    repeat (30) @(posedge clk_i);
    meas(40);
    `CHK(hb, 16);
    `CHK(hbn, 24);
    rd(IX_FLG, 8'h0F);
    // Duty zero keeps the true output low after the next wrap.
    wr(IX_BDL, 8'h00);
    repeat (25) @(posedge clk_i);
    meas(40);
    `CHK(hb, 0);
    `CHK(hbn, 40);
    conclude();
  end
endmodule
